// >>> hw/ifsb4_pkg.sv
// package: register map, field positions and bus constants for the flag bank
package ifsb4_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0]  IFSB4_FLAGS_ADDR  = 8'h00;
  localparam logic [7:0]  IFSB4_MASK_ADDR   = 8'h04;
  localparam logic [7:0]  IFSB4_EVENT_ADDR  = 8'h08;
  localparam logic [7:0]  IFSB4_EMASK_ADDR  = 8'h0c;
  // flag positions inside the 16-bit bank register
  localparam int          IFSB4_LVD_POS     = 8;
  localparam int          IFSB4_CRC_POS     = 3;
  localparam int          IFSB4_SPB_POS     = 2;
  localparam int          IFSB4_SPA_POS     = 1;
  // implemented bits of the bank register
  localparam logic [15:0] IFSB4_IMPL_MASK   = 16'h010e;
  localparam logic [15:0] IFSB4_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] IFSB4_MASK_RESET  = 16'h0000;
  localparam logic [3:0]  IFSB4_EV_RESET    = 4'h0;
  localparam int          IFSB4_NSRC        = 4;
  localparam logic [31:0] IFSB4_UNMAPPED    = 32'h0000_0000;

  // source request strobes, one per flag
  typedef struct packed {
    logic low_voltage;
    logic checksum_engine;
    logic serial_port_b_err;
    logic serial_port_a_err;
  } ifsb4_src_type;

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ifsb4_wb_req_type;
endpackage : ifsb4_pkg

// >>> hw/ifsb4_sync.sv
// two-stage synchroniser bank for the asynchronous request inputs
`timescale 1ns/1ps
module ifsb4_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second; nothing else reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : ifsb4_sync

// >>> hw/ifsb4_top.sv
// fourth interrupt flag bank with wishbone slave and masked interrupt line
// Overview of operation
// - bit 8 holds low-voltage request flag
// - bit 3 holds checksum engine request flag
// - bit 2 holds serial port b error
// - bit 1 holds serial port a error
// - flag reads one once source requested
// - bits 7 to 4 read zero
// - bits 15-9 and 0 zero, writes ignored
`timescale 1ns/1ps
module ifsb4_top
  import ifsb4_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // peripheral request levels, asynchronous
  input  wire ifsb4_src_type src_req,
  // combined interrupt
  output logic               irq
);
  ifsb4_wb_req_type req;
  ifsb4_src_type    src_sync;
  ifsb4_src_type    src_prev_reg;
  ifsb4_src_type    src_rise;
  logic [15:0]      flags_reg;
  logic [15:0]      flags_next;
  logic [15:0]      mask_reg;
  logic [3:0]       event_reg;
  logic [3:0]       event_next;
  logic [3:0]       emask_reg;
  logic [15:0]      set_vec;
  logic             bus_write;
  logic             irq_next;
  logic [31:0]      rd_data;
  logic [15:0]      mask_next;
  logic [3:0]       emask_next;

  // register map seen by software, one 32-bit word per register:
  //   0x00 flag bank, bits 8, 3, 2 and 1 read and write, all others read zero
  //   0x04 interrupt mask with the flag bank layout, unimplemented bits tied low
  //   0x08 sticky event log, one bit per source, write one to clear
  //   0x0c event log mask, one bit per source
  // anything else reads zero, ignores writes and is still acknowledged,
  // so a stray access never hangs the processor bus
  //
  // bus timing, one wait state:
  //   edge 1 sees cyc and stb with ack low and launches ack and read data
  //   edge 2 sees ack high with the request still held; a write lands here
  //   edge 3 sees ack low again, because ack never stands two cycles
  // a master that releases only after ack therefore always gives an idle gap
  //
  // request timing:
  //   a source level passes two flops before anything reads it
  //   the third flop keeps the previous level for the edge detector
  //   a held level sets its flag once; it must fall and rise again to re-arm
  //   flag, event bit and irq all change on the same edge
  // limitation: a pulse shorter than one clock may be missed entirely

  // map the source strobes onto their bank positions
  function automatic logic [15:0] ifsb4_place(input ifsb4_src_type s);
    logic [15:0] v;
    v = 16'h0000;
    v[IFSB4_LVD_POS] = s.low_voltage;
    v[IFSB4_CRC_POS] = s.checksum_engine;
    v[IFSB4_SPB_POS] = s.serial_port_b_err;
    v[IFSB4_SPA_POS] = s.serial_port_a_err;
    return v;
  endfunction : ifsb4_place

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] ifsb4_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
    logic [15:0] v;
    v = old;
    if (sel[0]) v[7:0] = d[7:0];
    if (sel[1]) v[15:8] = d[15:8];
    return v;
  endfunction : ifsb4_merge

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // request pins come from other domains
  ifsb4_sync #(
    .WIDTH (IFSB4_NSRC)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (src_req),
    .sync_out (src_sync)
  );

  // edge detect on synchronised levels so a held request sets once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_prev_reg <= '0;
    end else begin
      src_prev_reg <= src_sync;
    end
  end
  assign src_rise = src_sync & ~src_prev_reg;
  assign set_vec  = ifsb4_place(src_rise);

  // write strobe: lands on the edge where the master sees ack high
  assign bus_write = req.cyc && req.stb && req.we && wb_ack_o;

  // flag bank next value; hardware set beats a software clear
  always_comb begin
    flags_next = flags_reg;
    if (bus_write && req.adr == IFSB4_FLAGS_ADDR) begin
      flags_next = ifsb4_merge(flags_reg, req.dat, req.sel);
    end
    flags_next = (flags_next | set_vec) & IFSB4_IMPL_MASK;
  end

  // flag bank register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= IFSB4_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // mask next value; irq needs it to follow a mask write on the same edge
  always_comb begin
    mask_next = mask_reg;
    if (bus_write && req.adr == IFSB4_MASK_ADDR) begin
      mask_next = ifsb4_merge(mask_reg, req.dat, req.sel) & IFSB4_IMPL_MASK;
    end
  end

  // interrupt mask over the bank layout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= IFSB4_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // event mask next value, lane 0 only
  always_comb begin
    emask_next = emask_reg;
    if (bus_write && req.adr == IFSB4_EMASK_ADDR && req.sel[0]) begin
      emask_next = req.dat[3:0];
    end
  end

  // sticky event log, write one to clear; a new event wins over the clear
  always_comb begin
    event_next = event_reg;
    if (bus_write && req.adr == IFSB4_EVENT_ADDR && req.sel[0]) begin
      event_next = event_reg & ~req.dat[3:0];
    end
    event_next = event_next | src_rise;
  end

  // event log register and its mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_reg <= IFSB4_EV_RESET;
      emask_reg <= IFSB4_EV_RESET;
    end else begin
      event_reg <= event_next;
      emask_reg <= emask_next;
    end
  end

  // interrupt follows the next state so it appears with the flag
  assign irq_next = |(flags_next & mask_next) || |(event_next & emask_next);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // read mux; unmapped addresses return zero but still ack
  always_comb begin
    case (req.adr)
      IFSB4_FLAGS_ADDR: rd_data = {16'h0000, flags_reg & IFSB4_IMPL_MASK};
      IFSB4_MASK_ADDR:  rd_data = {16'h0000, mask_reg};
      IFSB4_EVENT_ADDR: rd_data = {28'h0000000, event_reg};
      IFSB4_EMASK_ADDR: rd_data = {28'h0000000, emask_reg};
      default:          rd_data = IFSB4_UNMAPPED;
    endcase
  end

  // one-wait-state ack, one cycle high per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
    end
  end

  // read data register; loaded every cycle, only meaningful beside ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_data;
    end
  end

  // checks
  a_unimpl_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (flags_reg & ~IFSB4_IMPL_MASK) == 16'h0000) else $error("unimplemented flag bit set");
  a_high_bits_zero: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) == IFSB4_FLAGS_ADDR |-> wb_dat_o[15:9] == 7'h00 && !wb_dat_o[0])
    else $error("flag read shows unimplemented bit");
  a_lvd_sets: assert property (@(posedge clk) disable iff (rst)
    src_rise.low_voltage |=> flags_reg[IFSB4_LVD_POS]) else $error("low voltage flag not set");
  a_crc_sets: assert property (@(posedge clk) disable iff (rst)
    src_rise.checksum_engine |=> flags_reg[IFSB4_CRC_POS]) else $error("checksum flag not set");
  a_spb_sets: assert property (@(posedge clk) disable iff (rst)
    src_rise.serial_port_b_err |=> flags_reg[IFSB4_SPB_POS]) else $error("port b flag not set");
  a_spa_sets: assert property (@(posedge clk) disable iff (rst)
    src_rise.serial_port_a_err |=> flags_reg[IFSB4_SPA_POS]) else $error("port a flag not set");
  a_flag_holds: assert property (@(posedge clk) disable iff (rst)
    !bus_write && set_vec == 16'h0000 |=> flags_reg == $past(flags_reg)) else $error("flag changed without cause");
  a_sw_clear: assert property (@(posedge clk) disable iff (rst)
    bus_write && req.adr == IFSB4_FLAGS_ADDR && req.sel[0] && !req.dat[IFSB4_CRC_POS] && !set_vec[IFSB4_CRC_POS]
    |=> !flags_reg[IFSB4_CRC_POS]) else $error("software clear lost");
  a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == (|(flags_reg & mask_reg) || |(event_reg & emask_reg))) else $error("irq disagrees with state");

  // bus answer and read path checks
  a_ack_answers: assert property (@(posedge clk) disable iff (rst)
    req.cyc && req.stb && !wb_ack_o |=> wb_ack_o) else $error("request not acknowledged");
  a_ack_idle: assert property (@(posedge clk) disable iff (rst)
    !req.cyc |=> !wb_ack_o) else $error("ack without request");
  a_read_flags: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) == IFSB4_FLAGS_ADDR |-> wb_dat_o == {16'h0000, $past(flags_reg)})
    else $error("flag read disagrees with bank");
  a_read_mask: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) == IFSB4_MASK_ADDR |-> wb_dat_o == {16'h0000, $past(mask_reg)})
    else $error("mask read disagrees with register");
  a_read_events: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) == IFSB4_EVENT_ADDR |-> wb_dat_o == {28'h0000000, $past(event_reg)})
    else $error("event read disagrees with log");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) != IFSB4_FLAGS_ADDR && $past(req.adr) != IFSB4_MASK_ADDR
    && $past(req.adr) != IFSB4_EVENT_ADDR && $past(req.adr) != IFSB4_EMASK_ADDR
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_mask_impl: assert property (@(posedge clk) disable iff (rst)
    (mask_reg & ~IFSB4_IMPL_MASK) == 16'h0000) else $error("mask holds unimplemented bit");

  // hardware set against software clear, and the edge detector
  a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
    bus_write && req.adr == IFSB4_FLAGS_ADDR && set_vec != 16'h0000
    |=> (flags_reg & $past(set_vec)) == $past(set_vec)) else $error("set lost to clear");
  a_edge_history: assert property (@(posedge clk) disable iff (rst)
    src_prev_reg == $past(src_sync)) else $error("edge detector history wrong");
  a_irq_from_flag: assert property (@(posedge clk) disable iff (rst)
    flags_reg[IFSB4_LVD_POS] && mask_reg[IFSB4_LVD_POS] |-> irq) else $error("unmasked flag without irq");

  // per-bit checks over the whole bank register
  for (genvar b = 0; b < 16; b++) begin : g_bit_chk
    if (IFSB4_IMPL_MASK[b]) begin : g_impl
      a_bit_write: assert property (@(posedge clk) disable iff (rst)
        bus_write && req.adr == IFSB4_FLAGS_ADDR && req.sel[b/8]
        |=> flags_reg[b] == ($past(req.dat[b]) || $past(set_vec[b])))
        else $error("flag bit did not take write");
    end else begin : g_unimpl
      a_bit_tied: assert property (@(posedge clk) disable iff (rst)
        !flags_reg[b] && !mask_reg[b]) else $error("unimplemented bit held a one");
    end
  end

  // per-source event log checks
  for (genvar g = 0; g < IFSB4_NSRC; g++) begin : g_src_chk
    a_event_sets: assert property (@(posedge clk) disable iff (rst)
      src_rise[g] |=> event_reg[g]) else $error("event bit not set");
    a_event_sticky: assert property (@(posedge clk) disable iff (rst)
      event_reg[g] && !(bus_write && req.adr == IFSB4_EVENT_ADDR && req.sel[0] && req.dat[g])
      |=> event_reg[g]) else $error("event bit lost");
    a_event_quiet: assert property (@(posedge clk) disable iff (rst)
      !event_reg[g] && !src_rise[g] |=> !event_reg[g]) else $error("event bit set without cause");
  end

  c_flag_read: cover property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(req.adr) == IFSB4_FLAGS_ADDR && wb_dat_o != 32'h0);
  c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_set_and_clear: cover property (@(posedge clk) disable iff (rst)
    bus_write && req.adr == IFSB4_EVENT_ADDR && |src_rise);
  c_mask_write: cover property (@(posedge clk) disable iff (rst)
    bus_write && req.adr == IFSB4_MASK_ADDR);
endmodule : ifsb4_top

// >>> verification/tb_interrupt_flag_status_bank4.sv
// self-checking testbench for the fourth interrupt flag bank
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin fails++; $display("BAD %0t %s", $time, msg); end end
module tb_interrupt_flag_status_bank4;
  import ifsb4_pkg::*;
  logic          clk;
  logic          rst;
  logic          cyc;
  logic          stb;
  logic          we;
  logic [3:0]    sel;
  logic [7:0]    adr;
  logic [31:0]   wdat;
  logic [31:0]   rdat;
  logic          ack;
  logic          irq;
  ifsb4_src_type src;
  int            fails;
  int            num_checks;
  int            cycles;
  int            pos [4] = '{1, 2, 3, 8};

  ifsb4_top u_ifsb4_top (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_req(src), .irq(irq)
  );

  // free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // verdict and end of run, shared by the main flow and the watchdog
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // one classic cycle; request held until ack is seen at a rising edge
  // no local limit: only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, exp, msg)
  endtask : rd_chk

  // a clean request pulse, long enough for the synchroniser
  task automatic pulse(input int i);
    @(posedge clk);
    src <= ifsb4_src_type'(4'h1 << i);
    repeat (3) @(posedge clk);
    src <= 4'h0;
    repeat (5) @(posedge clk);
  endtask : pulse

  task automatic t_reset();
    rd_chk(8'h00, 32'h0000_0000, "flags not clear after reset");
    rd_chk(8'h04, 32'h0000_0000, "mask not clear after reset");
    rd_chk(8'h08, 32'h0000_0000, "event log not clear after reset");
    rd_chk(8'h0c, 32'h0000_0000, "event mask not clear after reset");
    rd_chk(8'h10, 32'h0000_0000, "unmapped read not zero");
  endtask : t_reset

  task automatic t_rw();
    wr(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'h0000_010e, "unimplemented flag bits took a write");
    wr(8'h00, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000, "flags not cleared by software");
  endtask : t_rw

  // every source in turn must land on its own flag position only
  task automatic t_sources();
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd_chk(8'h00, 32'h1 << pos[i], "source set wrong flag");
      rd_chk(8'h08, 32'h1 << i, "event log bit wrong");
      `CHK(irq, 1'b0, "irq with all masks closed")
      wr(8'h00, 32'h0000_0000);
      wr(8'h08, 32'h0000_000f);
      rd_chk(8'h00, 32'h0000_0000, "serviced flag not cleared");
    end
  endtask : t_sources

  task automatic t_irq();
    pulse(3);
    wr(8'h04, 32'hffff_ffff);
    rd_chk(8'h04, 32'h0000_010e, "mask readback wrong");
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1, "irq missing for unmasked flag")
    wr(8'h00, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0, "irq held after flag cleared")
    wr(8'h0c, 32'h0000_000f);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1, "irq missing for unmasked event")
    wr(8'h08, 32'h0000_0008);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0, "irq held after event cleared")
    rd_chk(8'h08, 32'h0000_0000, "event log not cleared by write one");
  endtask : t_irq

  // watchdog; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0; adr = 8'h00;
    wdat = 32'h0000_0000; src = 4'h0; fails = 0; num_checks = 0; cycles = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_sources();
    t_irq();
    close_out();
  end
endmodule : tb_interrupt_flag_status_bank4
